// File: hw/dtsr_pkg.sv
package dtsr_pkg;
  // Register addresses, byte-wide register index
  localparam logic [7:0] DTSR_ADDR_GLOBAL = 8'h20; // Global action trigger
  localparam logic [7:0] DTSR_ADDR_CHACT  = 8'h21; // Channel action trigger
  localparam logic [7:0] DTSR_ADDR_GSTAT  = 8'h22; // General status / ident
  localparam logic [7:0] DTSR_ADDR_CMPST  = 8'h23; // Comparator status
  localparam logic [7:0] DTSR_ADDR_PINCFG = 8'h24; // Pin function config

  // Global trigger field layout
  localparam int DTSR_KEY_HI   = 15;
  localparam int DTSR_KEY_LO   = 12;
  localparam int DTSR_RST_HI   = 11;
  localparam int DTSR_RST_LO   = 8;
  localparam int DTSR_LOAD_B   = 7;
  localparam int DTSR_CLR_B    = 6;
  localparam int DTSR_FDUMP_B  = 4;
  localparam int DTSR_PROT_B   = 3;
  localparam int DTSR_ROW_B    = 2;
  localparam int DTSR_NVWR_B   = 1;
  localparam int DTSR_NVRL_B   = 0;
  localparam logic [3:0] DTSR_UNLOCK_CODE = 4'h5; // Unlock password
  localparam logic [3:0] DTSR_RESET_CODE  = 4'ha; // Soft reset code

  // Channel action: four bits per channel, channel 0 in top nibble
  localparam int DTSR_CH_CMPCLR = 3;
  localparam int DTSR_CH_MLO    = 2;
  localparam int DTSR_CH_MHI    = 1;
  localparam int DTSR_CH_RUN    = 0;

  // Status field positions
  localparam int DTSR_OTP_ERR_B  = 15;
  localparam int DTSR_USER_ERR_B = 14;
  localparam int DTSR_BUSY_LO    = 9;
  localparam int DTSR_PROT_FLAG_B = 8;
  localparam int DTSR_WIN_LO     = 4;
  localparam int DTSR_SYNC_LO    = 0;
  localparam logic [15:0] DTSR_RESET_VAL = 16'h0000;

  // Single-cycle action pulses towards the function engines
  typedef struct packed {
    logic       soft_reset;
    logic       load;
    logic       clear;
    logic       fault_dump;
    logic       protect;
    logic       row_read;
    logic       nv_write;
    logic       nv_reload;
    logic       unlock;
    logic [3:0] cmp_clear;
    logic [3:0] margin_low;
    logic [3:0] margin_high;
  } dtsr_pulse_t;

  // Register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } dtsr_req_t;
endpackage : dtsr_pkg

// File: hw/dtsr_regs.sv
`timescale 1ns/100ps
// What this block does
// - Key 0101 in bits 15..12 unlocks device
// - Code 1010 in bits 11..8 soft-resets
// - Load bit updates synchronous-update channels
// - Clear bit forces zero or mid code
// - Fault-dump bit launches dump, self-clears
// - Protect bit launches safe shutdown, self-clears
// - Row-read bit reads one NVM row
// - NVM write bit starts programming, self-clears
// - Nonvolatile_reload_trigger bit reloads map, self-clears
// - Per-channel bit clears latched comparator result
// - Per-channel margin-low trigger, self-clears
// - Per-channel margin-high trigger, self-clears
// - Level bit runs waveform while set
// - OTP CRC error, cleared by reset or soft reset
// - User CRC error, cleared by soft reset
// - Busy bits per channel, host avoids busy
// - Protect-done flag set, clears on read
// - Window results latched per latch enable
// - Synchronised comparator outputs shown directly
// - Clear select: 0 zero, 1 mid scale
// - Sync option gates output update source
// - Latch enable chooses latching window result
module dtsr_regs
  import dtsr_pkg::*;
#(
  parameter int          NCH     = 4,
  parameter logic [7:0]  PART_ID = 8'ha5 // Arbitrary identifier value
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire dtsr_req_t         req,
  output logic [15:0]            rdata,
  output logic                   rvalid,
  input  wire logic [NCH-1:0]    clear_target_select,
  input  wire logic [NCH-1:0]    sync_update_en,
  input  wire logic              window_latch_en,
  input  wire logic [NCH-1:0]    chan_busy,
  input  wire logic [NCH-1:0]    window_raw,
  input  wire logic [NCH-1:0]    comparator_sync_out,
  input  wire logic              otp_crc_fail,
  input  wire logic              user_crc_fail,
  input  wire logic              protect_done,
  input  wire logic              data_write,
  input  wire logic [NCH-1:0]    data_write_ch,
  input  wire logic              load_pin_fall,
  output dtsr_pulse_t            pulse_q,
  output logic [NCH-1:0]         output_update_q,
  output logic [NCH-1:0]         clear_mid_q,
  output logic [NCH-1:0]         waveform_run_q,
  output logic [15:0]            pin_function_config_q
);

  logic [15:0]    wdat;           // Write data shorthand
  logic           wr_global;      // Write to global trigger
  logic           wr_chact;       // Write to channel action
  logic           rd_cmp;         // Read of comparator status
  logic           otp_err_q;      // Sticky OTP load error
  logic           user_err_q;     // Sticky user load error
  logic           prot_flag_q;    // Protection completed
  logic [NCH-1:0] win_latch_q;    // Latched window results
  logic [NCH-1:0] win_view;       // Window result shown
  logic [NCH-1:0] cmp_clr;        // Comparator clear this cycle
  logic [NCH-1:0] mlo;            // Margin-low requests
  logic [NCH-1:0] mhi;            // Margin-high requests
  logic           unlock_hit;     // Unlock code written

  assign wdat      = req.wdata;
  assign wr_global = req.wr && (req.addr == DTSR_ADDR_GLOBAL);
  assign wr_chact  = req.wr && (req.addr == DTSR_ADDR_CHACT);
  assign rd_cmp    = req.rd && (req.addr == DTSR_ADDR_CMPST);
  assign unlock_hit = wdat[DTSR_KEY_HI:DTSR_KEY_LO] == DTSR_UNLOCK_CODE;

  // Per-channel field extraction, channel 0 in the top nibble
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      cmp_clr[c] = wr_chact && wdat[(NCH-1-c)*4 + DTSR_CH_CMPCLR];
      mlo[c]     = wr_chact && wdat[(NCH-1-c)*4 + DTSR_CH_MLO];
      mhi[c]     = wr_chact && wdat[(NCH-1-c)*4 + DTSR_CH_MHI];
    end
  end

  // Global and channel trigger pulses; none is stored, so bits read back as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= '0; // Every trigger lasts one cycle
      if (wr_global) begin
        pulse_q.unlock     <= unlock_hit;
        pulse_q.soft_reset <= wdat[DTSR_RST_HI:DTSR_RST_LO]
                              == DTSR_RESET_CODE;
        pulse_q.load       <= wdat[DTSR_LOAD_B];
        pulse_q.clear      <= wdat[DTSR_CLR_B];
        pulse_q.fault_dump <= wdat[DTSR_FDUMP_B];
        pulse_q.protect    <= wdat[DTSR_PROT_B];
        pulse_q.row_read   <= wdat[DTSR_ROW_B];
        pulse_q.nv_write   <= wdat[DTSR_NVWR_B];
        pulse_q.nv_reload  <= wdat[DTSR_NVRL_B];
      end
      pulse_q.cmp_clear   <= cmp_clr;
      pulse_q.margin_low  <= mlo;
      pulse_q.margin_high <= mhi;
    end
  end

  // Output update strobes per channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      output_update_q <= '0;
      clear_mid_q     <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (sync_update_en[c]) begin
          // Deferred update: pin edge or load strobe only
          output_update_q[c] <= load_pin_fall ||
            (wr_global && wdat[DTSR_LOAD_B]);
        end else begin
          // Immediate update after each data write
          output_update_q[c] <= data_write && data_write_ch[c];
        end
      end
      if (wr_global && wdat[DTSR_CLR_B]) begin
        clear_mid_q <= clear_target_select;
      end
    end
  end

  // Waveform run levels, readable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waveform_run_q <= '0;
    end else if (pulse_q.soft_reset) begin
      waveform_run_q <= '0;
    end else if (wr_chact) begin
      for (int c = 0; c < NCH; c++) begin
        waveform_run_q[c] <= wdat[(NCH-1-c)*4 + DTSR_CH_RUN];
      end
    end
  end

  // Load error flags; the set wins over a coincident soft reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      otp_err_q  <= 1'b0;
      user_err_q <= 1'b0;
    end else begin
      otp_err_q  <= otp_crc_fail ||
                    (otp_err_q && !pulse_q.soft_reset);
      user_err_q <= user_crc_fail ||
                    (user_err_q && !pulse_q.soft_reset);
    end
  end

  // Protect-done flag, cleared by reading; set wins over the read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prot_flag_q <= 1'b0;
    end else if (protect_done) begin
      prot_flag_q <= 1'b1;
    end else if (rd_cmp || pulse_q.protect || pulse_q.soft_reset) begin
      prot_flag_q <= 1'b0; // New run reads 0 until complete
    end
  end

  // Window latch: set by raw result, cleared per channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      win_latch_q <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        win_latch_q[c] <= window_raw[c] ||
          (win_latch_q[c] && !cmp_clr[c]);
      end
    end
  end
  assign win_view = window_latch_en ? win_latch_q
                                    : window_raw;

  // Pin function config, plain storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_function_config_q <= DTSR_RESET_VAL;
    end else if (req.wr && (req.addr == DTSR_ADDR_PINCFG)) begin
      pin_function_config_q <= wdat;
    end
  end

  // Read data, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata  <= '0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      rdata  <= '0;
      if (req.rd) begin
        case (req.addr)
          DTSR_ADDR_GLOBAL: rdata <= '0; // Triggers read 0
          DTSR_ADDR_CHACT: begin
            for (int c = 0; c < NCH; c++) begin
              rdata[(NCH-1-c)*4 + DTSR_CH_RUN] <= waveform_run_q[c];
            end
          end
          DTSR_ADDR_GSTAT: begin
            rdata[DTSR_OTP_ERR_B]  <= otp_err_q;
            rdata[DTSR_USER_ERR_B] <= user_err_q;
            rdata[DTSR_BUSY_LO +: NCH] <= chan_busy;
            rdata[7:0] <= PART_ID;
          end
          DTSR_ADDR_CMPST: begin
            rdata[DTSR_PROT_FLAG_B] <= prot_flag_q;
            rdata[DTSR_WIN_LO +: NCH] <= win_view;
            rdata[DTSR_SYNC_LO +: NCH] <= comparator_sync_out;
          end
          DTSR_ADDR_PINCFG: rdata <= pin_function_config_q;
          default: rdata <= '0; // Unmapped reads zero
        endcase
      end
    end
  end

endmodule : dtsr_regs

// File: tb/dtsr_host.sv
`timescale 1ns/100ps
// Host side of the register port, drives on falling edges
module dtsr_host
  import dtsr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rvalid,
  input  wire logic [15:0] rdata,
  output dtsr_req_t        req
);
  initial req = '0; // Idle bus at time zero
  // Single-cycle write strobe, then scrambled idle fields
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk) req <= '{1'b1, 1'b0, a, d};
    @(negedge clk) req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  // Read with a bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output bit ok);
    ok = 0;
    @(negedge clk) req <= '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk) req <= '{1'b0, 1'b0, ~a, 16'hffff};
    for (int n = 0; n < 3 && !ok; n++) begin
      if (rvalid) begin
        ok = 1;
        d = rdata;
      end else @(negedge clk);
    end
  endtask : rd
endmodule : dtsr_host

// File: tb/dtsr_regs_asserts.sv
`timescale 1ns/100ps
// Port-level timing checks of the trigger and status bank
module dtsr_regs_asserts
  import dtsr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire dtsr_req_t   req,
  input wire logic        rvalid,
  input wire dtsr_pulse_t pulse_q,
  input wire logic [3:0]  output_update_q,
  input wire logic [3:0]  sync_update_en,
  input wire logic [3:0]  waveform_run_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic gw; // Global trigger write
  logic cw; // Channel action write
  assign gw = req.wr && req.addr == DTSR_ADDR_GLOBAL;
  assign cw = req.wr && req.addr == DTSR_ADDR_CHACT;
  a_read_answer: assert property (req.rd |=> rvalid)
    else $error("no read answer");
  a_load_once: assert property (gw && req.wdata[7] ##1 !gw |=>
    !pulse_q.load) else $error("load pulse too long");
  a_load_update: assert property (pulse_q.load |->
    (output_update_q & sync_update_en) == sync_update_en)
    else $error("load missed a channel");
  a_soft_reset: assert property (gw && req.wdata[11:8] ==
    DTSR_RESET_CODE |=> pulse_q.soft_reset) else $error("no soft reset");
  a_unlock_key: assert property (gw && req.wdata[15:12] ==
    DTSR_UNLOCK_CODE |=> pulse_q.unlock) else $error("no unlock");
  a_unlock_none: assert property (gw && req.wdata[15:12] !=
    DTSR_UNLOCK_CODE |=> !pulse_q.unlock) else $error("false unlock");
  a_margin_low: assert property (cw && req.wdata[14] |=>
    pulse_q.margin_low[0]) else $error("no margin low");
  a_run_set: assert property (cw && req.wdata[12] |=>
    waveform_run_q[0]) else $error("run not set");
  a_run_clear: assert property (cw && !req.wdata[0] |=>
    !waveform_run_q[3]) else $error("run not cleared");
endmodule : dtsr_regs_asserts

// File: tb/test_dac_trigger_status_regs.sv
`timescale 1ns/100ps
module test_dac_trigger_status_regs;
  import dtsr_pkg::*;
  localparam logic [7:0] PID = 8'h3c; // Arbitrary identifier
  logic clk = 0, rst_n = 0;            // Clock, reset
  dtsr_req_t req;                      // Host request
  logic [15:0] rdata, pin_q, d, v;     // Bus data
  logic rvalid, dw, lpf, wle, otp, usr, pdn; // Strobes
  logic [3:0] cts, sue, busy, wraw, cso, dwc, upd, cmid, run, uacc;
  dtsr_pulse_t pq, pacc, pexp;         // Pulse capture
  int errors = 0, tests_run = 0, pcnt, seed = 88;
  bit ok;
  always #10 clk = ~clk;               // 50 MHz
  dtsr_host host (.clk(clk), .rvalid(rvalid), .rdata(rdata), .req(req));
  dtsr_regs #(.PART_ID(PID)) dut (.clk(clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .rvalid(rvalid), .clear_target_select(cts),
    .sync_update_en(sue), .window_latch_en(wle), .chan_busy(busy),
    .window_raw(wraw), .comparator_sync_out(cso), .otp_crc_fail(otp),
    .user_crc_fail(usr), .protect_done(pdn), .data_write(dw),
    .data_write_ch(dwc), .load_pin_fall(lpf), .pulse_q(pq),
    .output_update_q(upd), .clear_mid_q(cmid), .waveform_run_q(run),
    .pin_function_config_q(pin_q));
  // Gather pulses seen between writes
  always @(negedge clk) begin
    pacc = pacc | pq;
    pcnt += (pq != 0);
    uacc = uacc | upd;
  end
  task automatic print_verdict;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (e !== s) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Read and compare; a missing answer ends the run
  task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
    host.rd(a, v, ok);
    if (!ok) begin
      errors++;
      print_verdict();
    end
    chk(n, e, v);
  endtask : rchk
  // Clear capture, optionally write, let pulses settle
  task automatic gw(input logic [7:0] a, input logic [15:0] x, input bit w);
    @(posedge clk);
    pacc = '0; pcnt = 0; uacc = '0;
    if (w) host.wr(a, x);
    else @(negedge clk) {dw, lpf} = {a[0], a[1]};
    @(negedge clk) {dw, lpf} = 2'b00;
    repeat (2) @(negedge clk);
  endtask : gw
  initial begin
    {dw, lpf, wle, otp, usr, pdn, cts, sue, busy, wraw, cso, dwc} = '0;
    repeat (5) @(posedge clk);
    @(negedge clk) rst_n = 1;
    rchk("chact", DTSR_ADDR_CHACT, 16'h0000);
    rchk("cmpst", DTSR_ADDR_CMPST, 16'h0000);
    rchk("unmapped", 8'h30, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      if (i % 8 == 3) d[11:8] = DTSR_RESET_CODE;
      if (i % 8 == 5) d[15:12] = DTSR_UNLOCK_CODE;
      @(negedge clk) {sue, cts} = $random(seed);
      gw(DTSR_ADDR_GLOBAL, d, 1);
      pexp = '{d[11:8] == DTSR_RESET_CODE, d[7], d[6], d[4], d[3], d[2],
               d[1], d[0], d[15:12] == DTSR_UNLOCK_CODE, 4'h0, 4'h0, 4'h0};
      chk("pulses", pexp, pacc);
      chk("pulse_cycles", pexp != 0, pcnt);
      chk("load_upd", d[7] ? sue : 4'h0, uacc);
      if (d[6]) chk("clear_mid", cts, cmid);
    end
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      gw(DTSR_ADDR_CHACT, d, 1);
      pexp             = '0;
      pexp.cmp_clear   = {d[3], d[7], d[11], d[15]};
      pexp.margin_low  = {d[2], d[6], d[10], d[14]};
      pexp.margin_high = {d[1], d[5], d[9], d[13]};
      chk("ch_pulses", pexp, pacc);
      chk("ch_cycles", pexp != 0, pcnt);
      chk("run", {d[0], d[4], d[8], d[12]}, run);
      rchk("chact", DTSR_ADDR_CHACT, d & 16'h1111);
    end
    gw(DTSR_ADDR_GLOBAL, 16'h0a00, 1);
    chk("run_reset", 4'h0, run);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) {busy, cso, wraw} = $random(seed);
      repeat (4) @(negedge clk);
      rchk("gstat", DTSR_ADDR_GSTAT, {3'b000, busy, 1'b0, PID});
      rchk("cmpst", DTSR_ADDR_CMPST, {8'h00, wraw, cso});
    end
    @(negedge clk) {busy, cso, wraw, otp, usr, pdn} = 15'h0007;
    @(negedge clk) {otp, usr, pdn} = 3'b000;
    rchk("protect", DTSR_ADDR_CMPST, 16'h0100);
    rchk("protect_rd", DTSR_ADDR_CMPST, 16'h0000);
    rchk("crc_hold", DTSR_ADDR_GSTAT, {8'hc0, PID});
    gw(DTSR_ADDR_GLOBAL, 16'h0a00, 1);
    rchk("crc_clr", DTSR_ADDR_GSTAT, {8'h00, PID});
    @(negedge clk) {wle, wraw} = 5'h1f;
    @(negedge clk) wraw = 4'h0;
    repeat (4) @(negedge clk);
    rchk("latched", DTSR_ADDR_CMPST, 16'h00f0);
    gw(DTSR_ADDR_CHACT, 16'h8000, 1);
    repeat (4) @(negedge clk);
    rchk("latch_clr", DTSR_ADDR_CMPST, 16'h00e0);
    @(negedge clk) {sue, dwc} = 8'h5f;
    gw(8'h02, 16'h0000, 0);
    chk("pin_load", 4'h5, uacc);
    gw(8'h01, 16'h0000, 0);
    chk("data_write", 4'ha, uacc);
    d = $random(seed);
    gw(DTSR_ADDR_PINCFG, d, 1);
    chk("pin_cfg", d, pin_q);
    rchk("pin_rd", DTSR_ADDR_PINCFG, d);
    print_verdict();
  end
endmodule : test_dac_trigger_status_regs
bind dtsr_regs dtsr_regs_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .req(req), .rvalid(rvalid), .pulse_q(pulse_q),
  .output_update_q(output_update_q), .sync_update_en(sync_update_en),
  .waveform_run_q(waveform_run_q));
